// File: hdl/brx_status_regs.sv
// receive framer status, search counter and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module brx_status_regs
  import brx_pkg::*;
#(
  parameter int unsigned SEARCH_WIN_CYC_P = SEARCH_WIN_CYC
)
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // processor port
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  output logic      [7:0] cpu_rdata,
  // receive mode controls
  input  wire logic       rx_e1_select,
  input  wire logic       rx_crc_mf_enable,
  // live framer conditions
  input  wire logic       far_end_alarm,
  input  wire logic       all_ones_alarm,
  input  wire logic       signal_absent,
  input  wire logic       frame_loss,
  input  wire logic       frame_word_hunt,
  input  wire logic       signaling_mf_hunt,
  input  wire logic       crc_mf_hunt,
  // ds1 receive stream and framer events
  input  wire logic       rx_bit,
  input  wire logic       rx_bit_en,
  input  wire logic       fbit_en,
  input  wire logic       framing_bit_error,
  input  wire logic       density_window_fail,
  input  wire logic       realign_changed,
  input  wire logic       b8zs_codeword,
  // interrupt request
  output logic            irq_out
);

  logic [3:0]       rx_live_info1;
  logic [2:0]       hunt_q;
  logic [CSC_W-1:0] crc4_search_count;
  logic [7:0]       rx_alarm_irq_enable;
  logic [7:0]       rx_latched_alarms;
  logic [7:0]       rx_latched_ds1_events;
  logic [3:0]       live_now;
  logic [7:0]       alarm_set;
  logic [7:0]       ds1_set;
  logic [7:0]       ds1_raw;
  logic [7:0]       rx_live_info_e1;
  logic             wr_alarm;
  logic             wr_ds1;
  logic             wr_enable;
  brx_hunt_e        hunt_state;
  brx_hunt_e        next_hunt_state;
  logic [18:0]      win_cnt;
  logic             win_expired;
  logic             crc_sync_gained;
  logic [4:0]       zero_run;
  logic             zero_in;
  logic             hit_eight;
  logic             hit_sixteen;
  logic [5:0]       severe_framing_err_hist;
  logic [5:0]       next_severe_framing_err_hist;
  logic [2:0]       severe_framing_err_errs;

  // register write decode
  assign wr_alarm  = cpu_wr && (cpu_addr == ADDR_LATCH_ALRM);
  assign wr_ds1    = cpu_wr && (cpu_addr == ADDR_DS1_EV);
  assign wr_enable = cpu_wr && (cpu_addr == ADDR_IRQ_EN);

  // live condition capture; writes never reach these
  assign live_now = {far_end_alarm, all_ones_alarm,
                     signal_absent, frame_loss};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_live_info1 <= RST_LIVE1;
    end
    else
    begin
      rx_live_info1 <= live_now;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hunt_q <= RST_HUNT;
    end
    else
    begin
      hunt_q[2] <= crc_mf_hunt;
      hunt_q[1] <= signaling_mf_hunt;
      hunt_q[0] <= frame_word_hunt;
    end
  end

  // edges of the live conditions against their captured values
  assign alarm_set[7:4] = rx_live_info1 & ~live_now;
  assign alarm_set[3:0] = live_now & ~rx_live_info1;

  // crc-4 multiframe search window timer; the window restarts whenever
  // hunting stops, so a short drop of the hunt flag never counts
  always_comb
  begin
    next_hunt_state = hunt_state;
    case (hunt_state)
      BRX_IDLE:
      begin
        if (rx_e1_select && rx_crc_mf_enable && crc_mf_hunt)
        begin
          next_hunt_state = BRX_HUNT;
        end
      end
      BRX_HUNT:
      begin
        if (!(rx_e1_select && rx_crc_mf_enable && crc_mf_hunt))
        begin
          next_hunt_state = BRX_IDLE;
        end
      end
      default:
      begin
        next_hunt_state = BRX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hunt_state <= BRX_IDLE;
    end
    else
    begin
      hunt_state <= next_hunt_state;
    end
  end

  assign win_expired = (hunt_state == BRX_HUNT) &&
                       (next_hunt_state == BRX_HUNT) &&
                       (win_cnt == 19'(SEARCH_WIN_CYC_P - 1));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_cnt <= RST_WIN_CNT;
    end
    else if ((hunt_state != BRX_HUNT) || win_expired)
    begin
      win_cnt <= RST_WIN_CNT;
    end
    else
    begin
      win_cnt <= win_cnt + 19'h00001;
    end
  end

  // search count: sync gained is the end of the crc-4 hunt
  assign crc_sync_gained = hunt_q[2] && !crc_mf_hunt;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crc4_search_count <= RST_CSC;
    end
    else if (!rx_crc_mf_enable)
    begin
      crc4_search_count <= RST_CSC;
    end
    else if (crc_sync_gained)
    begin
      crc4_search_count <= RST_CSC;
    end
    else if (win_expired)
    begin
      // plain binary add rolls 63 over to 0
      crc4_search_count <= crc4_search_count + 6'h01;
    end
  end

  // count bit 1 is left out so five bits reach past 400 ms
  assign rx_live_info_e1 = {crc4_search_count[5:2],
                            crc4_search_count[0],
                            hunt_q[2], hunt_q[1], hunt_q[0]};

  // ds1 zero-run tracking, saturating at sixteen
  assign zero_in     = rx_bit_en && !rx_bit;
  assign hit_eight   = zero_in && (zero_run == ZRUN_EIGHT - 5'h01);
  assign hit_sixteen = zero_in && (zero_run == ZRUN_SIXTEEN - 5'h01);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_run <= RST_ZRUN;
    end
    else if (rx_bit_en && rx_bit)
    begin
      zero_run <= RST_ZRUN;
    end
    else if (zero_in && (zero_run != ZRUN_SIXTEEN))
    begin
      zero_run <= zero_run + 5'h01;
    end
  end

  // framing bit error history over the last six framing bits
  assign next_severe_framing_err_hist = {severe_framing_err_hist[4:0], framing_bit_error};
  assign severe_framing_err_errs = 3'($countones(next_severe_framing_err_hist));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      severe_framing_err_hist <= RST_SEVERE_FRAMING_ERR_HIST;
    end
    else if (fbit_en)
    begin
      severe_framing_err_hist <= next_severe_framing_err_hist;
    end
  end

  // ds1 events latch only while ds1 is selected, so the register
  // stays quiet in e1 mode where its content has no meaning
  always_comb
  begin
    ds1_raw = 8'h00;
    ds1_raw[EV_DENSITY]      = hit_sixteen || density_window_fail;
    ds1_raw[EV_REALIGN]      = realign_changed;
    ds1_raw[EV_EIGHT_ZERO]   = hit_eight;
    ds1_raw[EV_SIXTEEN_ZERO] = hit_sixteen;
    ds1_raw[EV_SEVERE_FE]    = fbit_en &&
                               (severe_framing_err_errs >= SEVERE_FRAMING_ERR_ERR_LIMIT);
    ds1_raw[EV_B8ZS]         = b8zs_codeword;
    ds1_raw[EV_FBIT_ERR]     = fbit_en && framing_bit_error;
  end

  assign ds1_set = rx_e1_select ? 8'h00 : ds1_raw;

  // latched status cells; inside each cell a set beats a written-one
  // clear in the same cycle, so an event that meets a clear is kept
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_latch
      brx_w1c_bit u_alarm
      (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .set_ev  (alarm_set[gi]),
        .clr_wr  (wr_alarm && cpu_wdata[gi]),
        .q       (rx_latched_alarms[gi])
      );
      brx_w1c_bit u_ds1
      (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .set_ev  (ds1_set[gi]),
        .clr_wr  (wr_ds1 && cpu_wdata[gi]),
        .q       (rx_latched_ds1_events[gi])
      );
    end
  endgenerate

  // interrupt enable register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_alarm_irq_enable <= RST_REG8;
    end
    else if (wr_enable)
    begin
      rx_alarm_irq_enable <= cpu_wdata;
    end
  end

  // interrupt request, one cycle behind the latched bits; ds1 events
  // are deliberately left out
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_out <= RST_IRQ;
    end
    else
    begin
      irq_out <= |(rx_latched_alarms & rx_alarm_irq_enable);
    end
  end

  // read data, held until the next read strobe; a read in the same
  // cycle as a write to the same register returns the old value
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_rdata <= RST_REG8;
    end
    else if (cpu_rd)
    begin
      case (cpu_addr)
        ADDR_LIVE1:
        begin
          cpu_rdata <= {4'h0, rx_live_info1};
        end
        ADDR_LIVE_E1:
        begin
          cpu_rdata <= rx_live_info_e1;
        end
        ADDR_LATCH_ALRM:
        begin
          cpu_rdata <= rx_latched_alarms;
        end
        ADDR_IRQ_EN:
        begin
          cpu_rdata <= rx_alarm_irq_enable;
        end
        ADDR_DS1_EV:
        begin
          cpu_rdata <= rx_latched_ds1_events;
        end
        default:
        begin
          cpu_rdata <= READ_UNMAPPED;
        end
      endcase
    end
  end

endmodule : brx_status_regs
`default_nettype wire

// File: include/brx_pkg.sv
// constants and types of the receive framer status and interrupt block
//
// Behaviour
// - E1: count each expired 8 ms CRC-4 multiframe search window.
// - clear search count on CRC-4 sync, and while CRC-4 mode is off.
// - six-bit count; register bits 7..3 show count bits 5..2 and 0.
// - search count wraps to zero past its maximum.
// - frame-word hunt flag is one while hunting frame alignment.
// - signaling multiframe hunt flag is one while hunting CAS alignment.
// - CRC multiframe hunt flag is one while hunting CRC-4 alignment.
// - E1 live register is meaningful only when E1 is selected.
// - latched bits 7..4 set when their live condition falls.
// - latched bits 3..0 set when their live condition rises.
// - latched bits clear only on a written one; zero leaves them.
// - each enable bit gates the same bit of latched alarms.
// - interrupt output is high while any enabled latched alarm is set.
// - DS1 event register never interrupts; meaningless in E1 mode.
// - DS1: latch density violation on over 15 zeros or sparse window.
// - latch alignment change when a resync moved the alignment.
// - latch eight-zero bit on any run of eight or more zeros.
// - latch sixteen-zero bit on any run of sixteen or more zeros.
// - latch severe framing error when 2 of 6 framing bits err.
// - latch codeword bit on every B8ZS codeword, decoding on or not.
// - live bits 3 and 2 show far-end alarm and all-ones alarm.
package brx_pkg;

  localparam logic [7:0] ADDR_LIVE1      = 8'h31;
  localparam logic [7:0] ADDR_LIVE_E1    = 8'h32;
  localparam logic [7:0] ADDR_LATCH_ALRM = 8'h33;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h34;
  localparam logic [7:0] ADDR_DS1_EV     = 8'h35;

  localparam logic [7:0] RST_REG8        = 8'h00;
  localparam logic [3:0] RST_LIVE1       = 4'h0;
  localparam logic [2:0] RST_HUNT        = 3'h0;
  localparam logic       RST_IRQ         = 1'h0;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  localparam int unsigned CSC_W          = 6;
  localparam logic [5:0] RST_CSC         = 6'h00;

  // ds1 event bit positions
  localparam int unsigned EV_DENSITY     = 7;
  localparam int unsigned EV_REALIGN     = 5;
  localparam int unsigned EV_EIGHT_ZERO  = 4;
  localparam int unsigned EV_SIXTEEN_ZERO = 3;
  localparam int unsigned EV_SEVERE_FE   = 2;
  localparam int unsigned EV_B8ZS        = 1;
  localparam int unsigned EV_FBIT_ERR    = 0;

  localparam logic [4:0] ZRUN_EIGHT      = 5'h08;
  localparam logic [4:0] ZRUN_SIXTEEN    = 5'h10;
  localparam logic [4:0] RST_ZRUN        = 5'h00;
  localparam int unsigned SEVERE_FRAMING_ERR_WINDOW    = 6;
  localparam logic [2:0] SEVERE_FRAMING_ERR_ERR_LIMIT  = 3'h2;
  localparam logic [5:0] RST_SEVERE_FRAMING_ERR_HIST   = 6'h00;

  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned SEARCH_WIN_MS  = 8;
  localparam int unsigned SEARCH_WIN_CYC = SEARCH_WIN_MS * CLK_KHZ;
  localparam logic [18:0] RST_WIN_CNT    = 19'h00000;

  typedef enum logic [1:0]
  {
    BRX_IDLE = 2'b01,
    BRX_HUNT = 2'b10
  } brx_hunt_e;

endpackage : brx_pkg

// File: hdl/brx_w1c_bit.sv
// one latched status bit, set by hardware, cleared by a written one
`timescale 1ns/1ps
`default_nettype none
module brx_w1c_bit
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // set and clear strobes
  input  wire logic set_ev,
  input  wire logic clr_wr,
  // latched state
  output logic      q
);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= 1'b0;
    end
    else if (set_ev)
    begin
      q <= 1'b1;
    end
    else if (clr_wr)
    begin
      q <= 1'b0;
    end
  end

endmodule : brx_w1c_bit
`default_nettype wire

// File: testbench/brx_status_monitor.sv
// port assertions for the receive status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module brx_status_monitor
  import brx_pkg::*;
#(
  parameter int unsigned SEARCH_WIN_CYC_P = SEARCH_WIN_CYC
)
(
  // clock, reset and processor port
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic       irq_out,
  // live conditions
  input wire logic       rx_crc_mf_enable,
  input wire logic       far_end_alarm,
  input wire logic       all_ones_alarm,
  input wire logic       signal_absent,
  input wire logic       frame_loss,
  input wire logic       frame_word_hunt,
  input wire logic       signaling_mf_hunt,
  input wire logic       crc_mf_hunt
);
  logic [3:0] al;
  logic [3:0] al_q;
  logic [2:0] hu;
  logic       chg;
  logic       en_wr;
  logic       clr_all;
  assign al = {far_end_alarm, all_ones_alarm, signal_absent, frame_loss};
  assign hu = {crc_mf_hunt, signaling_mf_hunt, frame_word_hunt};
  assign chg = al != al_q;
  assign en_wr = cpu_wr && cpu_addr == ADDR_IRQ_EN;
  assign clr_all = cpu_wr && cpu_addr == ADDR_LATCH_ALRM && cpu_wdata == 8'hFF;
  // previous alarm levels, to see when a latched bit may be set
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      al_q <= 4'h0;
    else
      al_q <= al;
  end
  default clocking mcb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  AST_UNMAPPED: assert property (
    cpu_rd && (cpu_addr < ADDR_LIVE1 || cpu_addr > ADDR_DS1_EV)
    |=> cpu_rdata == READ_UNMAPPED) else $error("unmapped read not zero");
  AST_LIVE1: assert property (
    cpu_rd && cpu_addr == ADDR_LIVE1 && $stable(al)
    |=> cpu_rdata == {4'h0, $past(al)}) else $error("live alarm readback");
  AST_HUNT: assert property (
    cpu_rd && cpu_addr == ADDR_LIVE_E1 && $stable(hu)
    |=> cpu_rdata[2:0] == $past(hu)) else $error("hunt flag readback");
  AST_CSC_OFF: assert property (
    cpu_rd && cpu_addr == ADDR_LIVE_E1 && !rx_crc_mf_enable
    && !$past(rx_crc_mf_enable) |=> cpu_rdata[7:3] == 5'h00)
    else $error("search count not held at zero");
  AST_IRQ_MASK: assert property (
    en_wr && cpu_wdata == 8'h00 |-> ##2 !irq_out)
    else $error("interrupt with all sources masked");
  AST_IRQ_CAUSE: assert property (
    $rose(irq_out) |-> $past(chg, 2) || $past(en_wr, 2))
    else $error("interrupt raised without cause");
  AST_IRQ_DROP: assert property (
    clr_all && !chg ##1 !chg |-> ##1 !irq_out)
    else $error("interrupt stays after clearing alarms");
  AST_RST_QUIET: assert property (
    $rose(arst_n) |-> !irq_out [*2]) else $error("interrupt after reset");
  cover property (en_wr ##2 irq_out);
  cover property ($fell(irq_out));
  cover property (cpu_rd && cpu_addr == ADDR_LIVE_E1 && crc_mf_hunt);
endmodule : brx_status_monitor

bind brx_status_regs brx_status_monitor #(
  .SEARCH_WIN_CYC_P(SEARCH_WIN_CYC_P)
) u_mon
(
  .clk_sys           (clk_sys),
  .arst_n            (arst_n),
  .cpu_addr          (cpu_addr),
  .cpu_wdata         (cpu_wdata),
  .cpu_wr            (cpu_wr),
  .cpu_rd            (cpu_rd),
  .cpu_rdata         (cpu_rdata),
  .irq_out           (irq_out),
  .rx_crc_mf_enable  (rx_crc_mf_enable),
  .far_end_alarm     (far_end_alarm),
  .all_ones_alarm    (all_ones_alarm),
  .signal_absent     (signal_absent),
  .frame_loss        (frame_loss),
  .frame_word_hunt   (frame_word_hunt),
  .signaling_mf_hunt (signaling_mf_hunt),
  .crc_mf_hunt       (crc_mf_hunt)
);
`default_nettype wire

// File: testbench/brx_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module brx_host_model
(
  // clock
  input  wire logic       clk_sys,
  // processor port
  output logic      [7:0] cpu_addr,
  output logic      [7:0] cpu_wdata,
  output logic            cpu_wr,
  output logic            cpu_rd,
  input  wire logic [7:0] cpu_rdata
);
  initial
  begin
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
  end
  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    @(negedge clk_sys);
    cpu_wr = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    v = cpu_rdata;
  endtask : rd
endmodule : brx_host_model
`default_nettype wire

// File: testbench/test_brx_status_regs.sv
// self-checking bench for the receive status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_brx_status_regs
  import brx_pkg::*;
;
  localparam int unsigned WIN = 20;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, d, m;
  logic       cpu_wr, cpu_rd, irq_out;
  logic [3:0] alm = 4'h0;
  logic [2:0] hunt = 3'h0;
  logic [2:0] pls = 3'h0;
  logic       e1 = 1'b1, crc_en = 1'b0, rbit = 1'b0, rbit_en = 1'b0;
  logic       fb_en = 1'b0, fb_err = 1'b0;
  logic [7:0] ev_bit [3] = '{8'h02, 8'h20, 8'h80};
  int         err_total = 0, check_count = 0, cyc = 0;

  always #12.5 clk_sys = ~clk_sys;

  brx_status_regs #(.SEARCH_WIN_CYC_P(WIN)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .rx_e1_select(e1), .rx_crc_mf_enable(crc_en),
    .far_end_alarm(alm[3]), .all_ones_alarm(alm[2]),
    .signal_absent(alm[1]), .frame_loss(alm[0]),
    .frame_word_hunt(hunt[0]), .signaling_mf_hunt(hunt[1]),
    .crc_mf_hunt(hunt[2]), .rx_bit(rbit), .rx_bit_en(rbit_en),
    .fbit_en(fb_en), .framing_bit_error(fb_err),
    .density_window_fail(pls[2]), .realign_changed(pls[1]),
    .b8zs_codeword(pls[0]), .irq_out(irq_out));

  brx_host_model u_host (.clk_sys(clk_sys), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata));

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic waitc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : waitc

  // search count shows bits 5..2 and 0 above the hunt flags
  function automatic logic [7:0] e1_exp(input logic [5:0] c,
                                        input logic [2:0] h);
    return {c[5:2], c[0], h};
  endfunction : e1_exp

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    void'($urandom(40));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    for (int a = 8'h30; a < 8'h37; a++)
      rdc(8'(a), RST_REG8);
    u_host.wr(ADDR_LIVE1, 8'hFF);
    u_host.wr(ADDR_LIVE_E1, 8'hFF);
    rdc(ADDR_LIVE1, 8'h00);
    rdc(ADDR_LIVE_E1, 8'h00);
    repeat (4)
    begin
      m = 8'($urandom);
      u_host.wr(ADDR_IRQ_EN, m);
      rdc(ADDR_IRQ_EN, m);
      rdc(8'h36 + 8'($urandom % 200), READ_UNMAPPED);
    end
    u_host.wr(ADDR_IRQ_EN, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      m = 8'h01 << i;
      alm[i] = 1'b1;
      waitc(3);
      rdc(ADDR_LIVE1, m);
      rdc(ADDR_LATCH_ALRM, m);
      chk({7'h00, irq_out}, 8'h00);
      u_host.wr(ADDR_IRQ_EN, m);
      waitc(2);
      chk({7'h00, irq_out}, 8'h01);
      u_host.wr(ADDR_LATCH_ALRM, ~m);
      rdc(ADDR_LATCH_ALRM, m);
      alm[i] = 1'b0;
      waitc(3);
      rdc(ADDR_LATCH_ALRM, m | (m << 4));
      u_host.wr(ADDR_LATCH_ALRM, m);
      rdc(ADDR_LATCH_ALRM, m << 4);
      chk({7'h00, irq_out}, 8'h00);
      u_host.wr(ADDR_LATCH_ALRM, 8'hFF);
    end
    fork
      u_host.wr(ADDR_LATCH_ALRM, 8'hFF);
      begin
        @(negedge clk_sys);
        alm[0] = 1'b1;
      end
    join
    rdc(ADDR_LATCH_ALRM, 8'h01);
    alm[0] = 1'b0;
    waitc(2);
    u_host.wr(ADDR_LATCH_ALRM, 8'hFF);
    crc_en = 1'b1;
    hunt = 3'b100;
    waitc(3 * WIN + 6);
    rdc(ADDR_LIVE_E1, e1_exp(6'h03, 3'b100));
    waitc(61 * WIN - 2);
    rdc(ADDR_LIVE_E1, e1_exp(6'h00, 3'b100));
    waitc(5 * WIN - 2);
    rdc(ADDR_LIVE_E1, e1_exp(6'h05, 3'b100));
    crc_en = 1'b0;
    waitc(2);
    rdc(ADDR_LIVE_E1, e1_exp(6'h00, 3'b100));
    crc_en = 1'b1;
    waitc(WIN + 10);
    hunt = 3'b011;
    waitc(2);
    rdc(ADDR_LIVE_E1, e1_exp(6'h00, 3'b011));
    hunt = 3'b000;
    e1 = 1'b0;
    rbit_en = 1'b1;
    waitc(8);
    rbit_en = 1'b0;
    rdc(ADDR_DS1_EV, 8'h10);
    rbit_en = 1'b1;
    waitc(8);
    rbit_en = 1'b0;
    rdc(ADDR_DS1_EV, 8'h98);
    u_host.wr(ADDR_DS1_EV, 8'hFF);
    rdc(ADDR_DS1_EV, 8'h00);
    rbit = 1'b1;
    rbit_en = 1'b1;
    waitc(1);
    rbit = 1'b0;
    waitc(7);
    rbit_en = 1'b0;
    rdc(ADDR_DS1_EV, 8'h00);
    rbit_en = 1'b1;
    waitc(1);
    rbit_en = 1'b0;
    rdc(ADDR_DS1_EV, 8'h10);
    u_host.wr(ADDR_DS1_EV, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      pls[i] = 1'b1;
      waitc(1);
      pls[i] = 1'b0;
      rdc(ADDR_DS1_EV, ev_bit[i]);
      u_host.wr(ADDR_DS1_EV, 8'hFF);
    end
    fb_en = 1'b1;
    fb_err = 1'b1;
    waitc(1);
    fb_err = 1'b0;
    waitc(4);
    fb_en = 1'b0;
    rdc(ADDR_DS1_EV, 8'h01);
    fb_en = 1'b1;
    fb_err = 1'b1;
    waitc(1);
    fb_en = 1'b0;
    fb_err = 1'b0;
    rdc(ADDR_DS1_EV, 8'h05);
    u_host.wr(ADDR_IRQ_EN, 8'hFF);
    waitc(2);
    chk({7'h00, irq_out}, 8'h00);
    conclude();
  end
endmodule : test_brx_status_regs
`default_nettype wire
